// file: rtl/dbgst_pkg.sv
// types of the debug status block
// assumes dbgst_regs.svh holds all numbers
package dbgst_pkg;
    typedef struct packed {
        logic wr;
        logic [7:0] idx;
        logic [31:0] rdata;
        logic [31:0] cfg_rdata;
        logic [10:0] stat;
        logic [31:0] pc;
        logic [31:0] sp;
        logic [7:0] rthr;
        logic [4:0] rreg;
        logic [2:0] cause;
        logic [1:0] src;
        logic [7:0] thr;
        logic [31:0] data;
        logic [7:0] halt;
        logic [7:0] halt_out;
        logic irq;
        logic [7:0][31:0] mbox;
        logic [3:0][31:0] iba;
        logic [3:0][31:0] ibc;
        logic [3:0][31:0] dwa;
        logic [3:0][31:0] dwb;
        logic [3:0][31:0] dwc;
    } dbgst_state_t;
endpackage : dbgst_pkg

// file: rtl/dbgst_regs.svh
// register indices, field positions and codes of the debug status block
// byte address of a register is four times its index
`ifndef DBGST_REGS_SVH
`define DBGST_REGS_SVH
`define DBGST_IDX_OSC 8'h07
`define DBGST_IDX_RAMSZ 8'h0C
`define DBGST_IDX_STAT 8'h10
`define DBGST_IDX_PC 8'h11
`define DBGST_IDX_SP 8'h12
`define DBGST_IDX_RTHR 8'h13
`define DBGST_IDX_RREG 8'h14
`define DBGST_IDX_CAUSE 8'h15
`define DBGST_IDX_DATA 8'h16
`define DBGST_IDX_HALT 8'h18
`define DBGST_IDX_MBOX 8'h20
`define DBGST_IDX_IBA 8'h30
`define DBGST_IDX_IBC 8'h40
`define DBGST_IDX_DWA 8'h50
`define DBGST_IDX_DWB 8'h60
`define DBGST_IDX_DWC 8'h70
`define DBGST_STAT_WMASK 11'h6DF
`define DBGST_STAT_ISSUE 8
`define DBGST_CTL_EN 0
`define DBGST_CTL_SEL 1
`define DBGST_DWC_LOAD 2
`define DBGST_CTL_THR_LSB 16
`define DBGST_CAUSE_HOST 3'h1
`define DBGST_CAUSE_CALL 3'h2
`define DBGST_CAUSE_IBRK 3'h3
`define DBGST_CAUSE_DWATCH 3'h4
`define DBGST_CAUSE_RWATCH 3'h5
`define DBGST_RAM_BYTES 32'h0008_0000
`endif

// file: rtl/dbgst_top.sv
// debug status, breakpoint and watchpoint registers of one tile
// assumes an ahb-lite master and processor cores on hclk
//
// How it works
// - oscillator counts are 16 bits, upper bits zero, never reset
// - four read-only counts at consecutive indices 0x07 to 0x0A
// - ram capacity register reads byte size, two low bits zero
// - saved status word captured on debugger entry with its bit meanings
// - saved program counter captured on entry, debug-writable
// - saved stack pointer captured on entry, debug-writable
// - register-read operands: 8-bit thread and 5-bit register number
// - 3-bit cause code of the debug interrupt, reset zero
// - 2-bit source index, zero for host and call, lowest wins
// - 8-bit causing thread, zero for host requests
// - data register gets watch address or resource identifier
// - halt mask stops threads whenever debug mode is inactive
// - eight mailbox words shared with tile configuration access
// - four instruction breakpoints compare pc against address
// - breakpoint bit 0 enables, bit 1 selects inequality
// - per-thread enable byte in bits 23:16 of each control
// - four watchpoints own first and second address registers
// - watch control bit 2 allows loads, bit 1 picks and or or
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "dbgst_regs.svh"
module dbgst_top
    import dbgst_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic dbg_mode,
    input wire logic dbg_enter,
    input wire logic [10:0] saved_status_word,
    input wire logic [31:0] saved_program_counter,
    input wire logic [31:0] saved_stack_pointer,
    input wire logic host_req,
    input wire logic call_valid,
    input wire logic [7:0] call_thread,
    input wire logic exec_valid,
    input wire logic [2:0] exec_thread,
    input wire logic [31:0] exec_pc,
    input wire logic mem_valid,
    input wire logic mem_load,
    input wire logic [2:0] mem_thread,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] res_hit,
    input wire logic [2:0] res_thread,
    input wire logic [31:0] res_id,
    input wire logic [3:0] osc_tick,
    input wire logic cfg_wr,
    input wire logic [2:0] cfg_idx,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic dbg_irq,
    output logic [7:0] thread_halt,
    output logic [7:0] regread_thread,
    output logic [4:0] regread_reg
);

    // ====================================================
    // oscillator counters
    // ====================================================
    logic [3:0] osc_s1;
    logic [3:0] osc_s2;
    logic [3:0] osc_s3;
    logic [3:0][15:0] osc_cnt;

    // counts kept through reset
    // no reset here: counts must survive a system reset
    always_ff @(posedge hclk) begin
        osc_s1 <= osc_tick;
        osc_s2 <= osc_s1;
        osc_s3 <= osc_s2;
        for (int i = 0; i < 4; i++) begin
            if (osc_s2[i] && !osc_s3[i]) begin
                osc_cnt[i] <= osc_cnt[i] + 16'h0001;
            end
        end
    end

    // ====================================================
    // comparators
    // ====================================================
    dbgst_state_t s_q;
    dbgst_state_t s_d;
    logic [3:0] ib_hit;
    logic [3:0] dw_hit;
    logic [1:0] ib_low;
    logic [1:0] dw_low;
    logic [1:0] rw_low;
    logic take;

    always_comb begin
        ib_hit = 4'h0;
        dw_hit = 4'h0;
        for (int i = 0; i < 4; i++) begin
            ib_hit[i] = exec_valid && s_q.ibc[i][`DBGST_CTL_EN]
                && s_q.ibc[i][`DBGST_CTL_THR_LSB + exec_thread]
                && ((exec_pc == s_q.iba[i])
                    ^ s_q.ibc[i][`DBGST_CTL_SEL]);
            dw_hit[i] = mem_valid && s_q.dwc[i][`DBGST_CTL_EN]
                && s_q.dwc[i][`DBGST_CTL_THR_LSB + mem_thread]
                && (!mem_load || s_q.dwc[i][`DBGST_DWC_LOAD])
                && (s_q.dwc[i][`DBGST_CTL_SEL]
                    ? (mem_addr == s_q.dwa[i]
                       || mem_addr == s_q.dwb[i])
                    : (mem_addr == s_q.dwa[i]
                       && mem_addr == s_q.dwb[i]));
        end
    end

    always_comb begin
        ib_low = 2'h0;
        dw_low = 2'h0;
        rw_low = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (ib_hit[i]) begin
                ib_low = 2'(i);
            end
            if (dw_hit[i]) begin
                dw_low = 2'(i);
            end
            if (res_hit[i]) begin
                rw_low = 2'(i);
            end
        end
    end

    // entry only outside debug mode and one pulse at a time
    assign take = !dbg_mode && !s_q.irq
        && (host_req || call_valid || (|ib_hit) || (|dw_hit)
            || (|res_hit));

    // ====================================================
    // next state
    // ====================================================
    logic acc;
    logic bus_wr;
    logic [7:0] widx;

    assign acc = hsel && htrans[1] && hready;
    assign widx = s_q.idx;
    assign bus_wr = s_q.wr && dbg_mode;

    always_comb begin
        s_d = s_q;
        s_d.wr = acc && hwrite;
        s_d.idx = acc ? haddr[9:2] : s_q.idx;
        s_d.irq = take;
        s_d.halt_out = dbg_mode ? 8'h00 : s_q.halt;
        // software writes first, hardware capture wins after
        if (bus_wr) begin
            unique case (widx)
                `DBGST_IDX_STAT: begin
                    s_d.stat = (s_q.stat & ~`DBGST_STAT_WMASK)
                        | (hwdata[10:0] & `DBGST_STAT_WMASK);
                end
                `DBGST_IDX_PC: s_d.pc = hwdata;
                `DBGST_IDX_SP: s_d.sp = hwdata;
                `DBGST_IDX_RTHR: s_d.rthr = hwdata[7:0];
                `DBGST_IDX_RREG: s_d.rreg = hwdata[4:0];
                `DBGST_IDX_CAUSE: begin
                    s_d.cause = hwdata[2:0];
                    s_d.thr = hwdata[15:8];
                    s_d.src = hwdata[17:16];
                end
                `DBGST_IDX_DATA: s_d.data = hwdata;
                `DBGST_IDX_HALT: s_d.halt = hwdata[7:0];
                default: begin
                    for (int i = 0; i < 8; i++) begin
                        if (widx == `DBGST_IDX_MBOX + 8'(i)) begin
                            s_d.mbox[i] = hwdata;
                        end
                    end
                    for (int i = 0; i < 4; i++) begin
                        if (widx == `DBGST_IDX_IBA + 8'(i)) begin
                            s_d.iba[i] = hwdata;
                        end
                        if (widx == `DBGST_IDX_IBC + 8'(i)) begin
                            s_d.ibc[i] = hwdata & 32'h00FF_0003;
                        end
                        if (widx == `DBGST_IDX_DWA + 8'(i)) begin
                            s_d.dwa[i] = hwdata;
                        end
                        if (widx == `DBGST_IDX_DWB + 8'(i)) begin
                            s_d.dwb[i] = hwdata;
                        end
                        if (widx == `DBGST_IDX_DWC + 8'(i)) begin
                            s_d.dwc[i] = hwdata & 32'h00FF_0007;
                        end
                    end
                end
            endcase
        end
        // shared mailbox, config port
        // config side ignores debug mode; a bus write the same
        // cycle to the same word loses
        if (cfg_wr) begin
            s_d.mbox[cfg_idx] = cfg_wdata;
        end
        s_d.cfg_rdata = s_d.mbox[cfg_idx];
        if (dbg_enter) begin
            s_d.stat = saved_status_word;
            s_d.pc = saved_program_counter;
            s_d.sp = saved_stack_pointer;
        end
        if (take) begin
            s_d.src = 2'h0;
            s_d.data = s_q.data;
            if (host_req) begin
                s_d.cause = `DBGST_CAUSE_HOST;
                s_d.thr = 8'h00;
            end else if (call_valid) begin
                s_d.cause = `DBGST_CAUSE_CALL;
                s_d.thr = call_thread;
            end else if (|ib_hit) begin
                s_d.cause = `DBGST_CAUSE_IBRK;
                s_d.thr = {5'h00, exec_thread};
                s_d.src = ib_low;
            end else if (|dw_hit) begin
                s_d.cause = `DBGST_CAUSE_DWATCH;
                s_d.thr = {5'h00, mem_thread};
                s_d.src = dw_low;
                s_d.data = mem_addr;
            end else begin
                s_d.cause = `DBGST_CAUSE_RWATCH;
                s_d.thr = {5'h00, res_thread};
                s_d.src = rw_low;
                s_d.data = res_id;
            end
        end
        // read data latched in the address phase
        s_d.rdata = s_q.rdata;
        if (acc && !hwrite) begin
            s_d.rdata = 32'h0000_0000;
            unique case (haddr[9:2])
                `DBGST_IDX_OSC: s_d.rdata = {16'h0000, osc_cnt[0]};
                `DBGST_IDX_OSC + 8'h01: s_d.rdata = {16'h0000, osc_cnt[1]};
                `DBGST_IDX_OSC + 8'h02: s_d.rdata = {16'h0000, osc_cnt[2]};
                `DBGST_IDX_OSC + 8'h03: s_d.rdata = {16'h0000, osc_cnt[3]};
                `DBGST_IDX_RAMSZ: begin
                    s_d.rdata = `DBGST_RAM_BYTES & 32'hFFFF_FFFC;
                end
                `DBGST_IDX_STAT: s_d.rdata = {21'h000000, s_q.stat};
                `DBGST_IDX_PC: s_d.rdata = s_q.pc;
                `DBGST_IDX_SP: s_d.rdata = s_q.sp;
                `DBGST_IDX_RTHR: s_d.rdata = {24'h000000, s_q.rthr};
                `DBGST_IDX_RREG: s_d.rdata = {27'h0000000, s_q.rreg};
                `DBGST_IDX_CAUSE: begin
                    s_d.rdata = {14'h0000, s_q.src, s_q.thr,
                        5'h00, s_q.cause};
                end
                `DBGST_IDX_DATA: s_d.rdata = s_q.data;
                `DBGST_IDX_HALT: s_d.rdata = {24'h000000, s_q.halt};
                default: begin
                    for (int i = 0; i < 8; i++) begin
                        if (haddr[9:2] == `DBGST_IDX_MBOX + 8'(i)) begin
                            s_d.rdata = s_q.mbox[i];
                        end
                    end
                    for (int i = 0; i < 4; i++) begin
                        if (haddr[9:2] == `DBGST_IDX_IBA + 8'(i)) begin
                            s_d.rdata = s_q.iba[i];
                        end
                        if (haddr[9:2] == `DBGST_IDX_IBC + 8'(i)) begin
                            s_d.rdata = s_q.ibc[i];
                        end
                        if (haddr[9:2] == `DBGST_IDX_DWA + 8'(i)) begin
                            s_d.rdata = s_q.dwa[i];
                        end
                        if (haddr[9:2] == `DBGST_IDX_DWB + 8'(i)) begin
                            s_d.rdata = s_q.dwb[i];
                        end
                        if (haddr[9:2] == `DBGST_IDX_DWC + 8'(i)) begin
                            s_d.rdata = s_q.dwc[i];
                        end
                    end
                end
            endcase
        end
    end

    // ====================================================
    // state register and outputs
    // ====================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // zero wait states: every transfer completes in one data phase
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign cfg_rdata = s_q.cfg_rdata;
    assign dbg_irq = s_q.irq;
    assign thread_halt = s_q.halt_out;
    assign regread_thread = s_q.rthr;
    assign regread_reg = s_q.rreg;

    // ====================================================
    // assertions
    // ====================================================
    AST_HALT_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
        !dbg_mode |=> thread_halt == $past(s_q.halt))
        else $error("halt mask not applied outside debug mode");

    AST_HALT_FREE: assert property (@(posedge hclk) disable iff (!hresetn)
        dbg_mode |=> thread_halt == 8'h00)
        else $error("threads halted during debug mode");

    AST_CAUSE_RANGE: assert property (@(posedge hclk)
        disable iff (!hresetn)
        dbg_irq |-> s_q.cause >= 3'h1 && s_q.cause <= 3'h5)
        else $error("cause code out of range on entry");

    AST_HOST_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        take && host_req |=> s_q.thr == 8'h00 && s_q.src == 2'h0
        && s_q.cause == 3'h1)
        else $error("host entry left thread or source nonzero");

    AST_IB_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
        take && !host_req && !call_valid && ib_hit[0]
        |=> s_q.src == 2'h0 && s_q.cause == 3'h3)
        else $error("breakpoint zero not reported");

    AST_DW_ADDR: assert property (@(posedge hclk) disable iff (!hresetn)
        dbg_irq && s_q.cause == 3'h4
        |-> s_q.data == $past(mem_addr))
        else $error("watch address not captured");

    AST_WR_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
        s_q.wr && !dbg_mode && !dbg_enter
        |=> $stable(s_q.pc) && $stable(s_q.halt))
        else $error("register changed by write outside debug mode");

    AST_CAUSE_HOLD: assert property (@(posedge hclk)
        disable iff (!hresetn)
        !take && !bus_wr |=> $stable(s_q.cause) && $stable(s_q.thr)
        && $stable(s_q.src))
        else $error("cause changed without entry");

    AST_IRQ_PULSE: assert property (@(posedge hclk)
        disable iff (!hresetn)
        dbg_irq |=> !dbg_irq)
        else $error("debug interrupt longer than one cycle");

    AST_IB_DISABLED: assert property (@(posedge hclk)
        disable iff (!hresetn)
        !s_q.ibc[0][0] |-> !ib_hit[0])
        else $error("disabled breakpoint fired");

endmodule : dbgst_top

// file: verification/dbgst_core_model.sv
// behavioural model of the cores beside the status block
// assumes the block raises dbg_irq as a one-cycle pulse on hclk
`timescale 1ns/1ps
// ======================================================================
// core side: enters debug mode on dbg_irq, leaves on resume
module dbgst_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic dbg_irq,
    input wire logic resume,
    output logic dbg_mode,
    output logic dbg_enter,
    output logic [10:0] saved_status_word,
    output logic [31:0] saved_program_counter,
    output logic [31:0] saved_stack_pointer
);
    localparam logic [10:0] STAT_VAL = 11'h100;
    localparam logic [31:0] PC_VAL = 32'h1234_5678;
    localparam logic [31:0] SP_VAL = 32'h0001_FFF0;

    // status word with issue bit set
    // saved words only valid with the entry strobe, inverted elsewhere
    // so a capture at the wrong cycle shows up
    assign saved_status_word = dbg_enter ? STAT_VAL : ~STAT_VAL;
    assign saved_program_counter = dbg_enter ? PC_VAL : ~PC_VAL;
    assign saved_stack_pointer = dbg_enter ? SP_VAL : ~SP_VAL;

    // mode held until resumed
    // mode rises one cycle after the interrupt, with the entry strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbg_mode <= 1'b0;
            dbg_enter <= 1'b0;
        end else begin
            dbg_enter <= dbg_irq;
            if (dbg_irq) begin
                dbg_mode <= 1'b1;
            end else if (resume) begin
                dbg_mode <= 1'b0;
            end
        end
    end
endmodule : dbgst_core_model

// file: verification/dbgst_top_tb.sv
// self-checking bench of the debug status block over ahb-lite
// assumes hreadyout feeds hready and the core model answers dbg_irq
`timescale 1ns/1ps
`include "dbgst_regs.svh"
module dbgst_top_tb
    import dbgst_pkg::*;
;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hreadyout, hresp, dbg_mode, dbg_enter, dbg_irq, resume = 1'b0;
    logic [31:0] hrdata, cfg_rdata, pc_w, sp_w, exec_pc = 32'h0000_0000;
    logic [31:0] mem_addr = 32'h0000_0000, res_id = 32'h0000_0000;
    logic [31:0] cfg_wdata = 32'h0000_0000;
    logic [10:0] stat_w;
    logic host_req = 1'b0, call_valid = 1'b0, exec_valid = 1'b0;
    logic mem_valid = 1'b0, mem_load = 1'b0, cfg_wr = 1'b0;
    logic [7:0] call_thread = 8'h00, thread_halt, regread_thread;
    logic [2:0] exec_thread = 3'h0, mem_thread = 3'h0, res_thread = 3'h0;
    logic [2:0] cfg_idx = 3'h0;
    logic [3:0] res_hit = 4'h0, osc_tick = 4'h0;
    logic [4:0] regread_reg;
    int miscompares = 0, n_tests = 0;

    // ==================================================================
    // clock and instances
    always #50 hclk = ~hclk;

    dbgst_top dbgst_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .dbg_mode(dbg_mode), .dbg_enter(dbg_enter),
        .saved_status_word(stat_w), .saved_program_counter(pc_w),
        .saved_stack_pointer(sp_w), .host_req(host_req),
        .call_valid(call_valid), .call_thread(call_thread),
        .exec_valid(exec_valid), .exec_thread(exec_thread),
        .exec_pc(exec_pc), .mem_valid(mem_valid), .mem_load(mem_load),
        .mem_thread(mem_thread), .mem_addr(mem_addr), .res_hit(res_hit),
        .res_thread(res_thread), .res_id(res_id), .osc_tick(osc_tick),
        .cfg_wr(cfg_wr), .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .dbg_irq(dbg_irq),
        .thread_halt(thread_halt), .regread_thread(regread_thread),
        .regread_reg(regread_reg));

    dbgst_core_model dbgst_core_model_i (.hclk(hclk), .hresetn(hresetn),
        .dbg_irq(dbg_irq), .resume(resume), .dbg_mode(dbg_mode),
        .dbg_enter(dbg_enter), .saved_status_word(stat_w),
        .saved_program_counter(pc_w), .saved_stack_pointer(sp_w));

    // ==================================================================
    // shared helpers
    task automatic wrap_up();
        if (miscompares == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // bounded wait: 0 ready, 1 interrupt, 2 debug mode, 3 normal mode
    task automatic wait_for(input int sel);
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge hclk);
            if ((sel == 0 ? hreadyout : sel == 1 ? dbg_irq :
                 sel == 2 ? dbg_mode : !dbg_mode) === 1'b1) break;
        end
        if (i == 40) begin
            miscompares++;
            wrap_up();
        end
    endtask : wait_for

    // one single word transfer, entered right after a rising edge
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        wait_for(0);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_for(0);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0000_0000);
        @(posedge hclk);
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, idx, 32'h0000_0000, x);
        check(x, e);
    endtask : rdc

    // cause word: source 17:16, thread 15:8, code 2:0
    function automatic logic [31:0] cw(input logic [1:0] s,
                                       input logic [7:0] t,
                                       input logic [2:0] c);
        return {14'h0, s, t, 5'h0, c};
    endfunction : cw

    task automatic enter(input logic [31:0] e);
        wait_for(1);
        wait_for(2);
        rdc(`DBGST_IDX_CAUSE, e);
    endtask : enter

    task automatic leave();
        resume <= 1'b1;
        wait_for(3);
        resume <= 1'b0;
        @(posedge hclk);
    endtask : leave

    // no debug interrupt may follow a non-matching event
    task automatic quiet();
        repeat (3) begin
            @(posedge hclk);
            check({31'h0, dbg_irq}, 32'h0000_0000);
        end
    endtask : quiet

    task automatic exec(input logic [2:0] t, input logic [31:0] pc);
        exec_valid <= 1'b1;
        exec_thread <= t;
        exec_pc <= pc;
        @(posedge hclk);
        exec_valid <= 1'b0;
    endtask : exec

    task automatic host();
        host_req <= 1'b1;
        @(posedge hclk);
        host_req <= 1'b0;
        enter(cw(2'd0, 8'h00, `DBGST_CAUSE_HOST));
    endtask : host

    // ==================================================================
    // scenarios
    task automatic t_reset();
        logic [31:0] x;
        rdc(`DBGST_IDX_CAUSE, 32'h0000_0000);
        rdc(`DBGST_IDX_IBC, 32'h0000_0000);
        rdc(`DBGST_IDX_IBC + 8'h03, 32'h0000_0000);
        rdc(`DBGST_IDX_RAMSZ, `DBGST_RAM_BYTES);
        repeat (8) begin
            osc_tick <= ~osc_tick;
            @(posedge hclk);
        end
        repeat (10) @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, `DBGST_IDX_OSC + 8'(i), 32'h0000_0000, x);
            check({16'h0, x[31:16]}, 32'h0000_0000);
        end
        rdc(8'h0B, 32'h0000_0000);
    endtask : t_reset

    task automatic t_entry();
        host_req <= 1'b1;
        call_valid <= 1'b1;
        call_thread <= 8'h07;
        @(posedge hclk);
        host_req <= 1'b0;
        call_valid <= 1'b0;
        enter(cw(2'd0, 8'h00, `DBGST_CAUSE_HOST));
        rdc(`DBGST_IDX_STAT, 32'h0000_0100);
        rdc(`DBGST_IDX_PC, 32'h1234_5678);
        rdc(`DBGST_IDX_SP, 32'h0001_FFF0);
        wr(`DBGST_IDX_STAT, 32'hFFFF_FFFF);
        rdc(`DBGST_IDX_STAT, 32'h0000_07DF);
        wr(`DBGST_IDX_PC, 32'hCAFE_0011);
        rdc(`DBGST_IDX_PC, 32'hCAFE_0011);
        wr(`DBGST_IDX_RTHR, 32'hFFFF_FFFF);
        wr(`DBGST_IDX_RREG, 32'hFFFF_FFFF);
        rdc(`DBGST_IDX_RTHR, 32'h0000_00FF);
        rdc(`DBGST_IDX_RREG, 32'h0000_001F);
        check({19'h0, regread_reg, regread_thread}, 32'h0000_1FFF);
        leave();
        call_valid <= 1'b1;
        @(posedge hclk);
        call_valid <= 1'b0;
        enter(cw(2'd0, 8'h07, `DBGST_CAUSE_CALL));
    endtask : t_entry

    task automatic t_halt_mbox();
        wr(`DBGST_IDX_HALT, 32'h0000_005A);
        check({24'h0, thread_halt}, 32'h0000_0000);
        wr(`DBGST_IDX_MBOX + 8'h07, 32'h5A5A_0707);
        cfg_idx <= 3'h7;
        repeat (2) @(posedge hclk);
        check(cfg_rdata, 32'h5A5A_0707);
        cfg_wr <= 1'b1;
        cfg_idx <= 3'h0;
        cfg_wdata <= 32'hA5A5_0000;
        @(posedge hclk);
        cfg_wr <= 1'b0;
        rdc(`DBGST_IDX_MBOX, 32'hA5A5_0000);
        leave();
        repeat (2) @(posedge hclk);
        check({24'h0, thread_halt}, 32'h0000_005A);
        wr(`DBGST_IDX_HALT, 32'h0000_0000);
        rdc(`DBGST_IDX_HALT, 32'h0000_005A);
    endtask : t_halt_mbox

    task automatic t_ibreak();
        host();
        for (int i = 1; i < 3; i++) begin
            wr(`DBGST_IDX_IBA + 8'(i), 32'h0000_0100);
            wr(`DBGST_IDX_IBC + 8'(i), 32'h0008_0001);
        end
        leave();
        exec(3'h3, 32'h0000_0100);
        enter(cw(2'd1, 8'h03, `DBGST_CAUSE_IBRK));
        wr(`DBGST_IDX_IBC + 8'h01, 32'h0000_0000);
        wr(`DBGST_IDX_IBC + 8'h02, 32'h0008_0003);
        leave();
        exec(3'h3, 32'h0000_0100);
        quiet();
        exec(3'h2, 32'h0000_0104);
        quiet();
        exec(3'h3, 32'h0000_0104);
        enter(cw(2'd2, 8'h03, `DBGST_CAUSE_IBRK));
    endtask : t_ibreak

    task automatic t_watch();
        wr(`DBGST_IDX_DWA, 32'h0000_2000);
        wr(`DBGST_IDX_DWB, 32'h0000_3000);
        wr(`DBGST_IDX_DWC, 32'h0001_0003);
        rdc(`DBGST_IDX_DWB, 32'h0000_3000);
        leave();
        mem_valid <= 1'b1;
        mem_load <= 1'b1;
        mem_addr <= 32'h0000_2000;
        @(posedge hclk);
        mem_load <= 1'b0;
        mem_addr <= 32'h0000_3000;
        @(posedge hclk);
        mem_valid <= 1'b0;
        enter(cw(2'd0, 8'h00, `DBGST_CAUSE_DWATCH));
        rdc(`DBGST_IDX_DATA, 32'h0000_3000);
        leave();
        res_hit <= 4'b0110;
        res_thread <= 3'h5;
        res_id <= 32'hABCD_0001;
        @(posedge hclk);
        res_hit <= 4'b0000;
        enter(cw(2'd1, 8'h05, `DBGST_CAUSE_RWATCH));
        rdc(`DBGST_IDX_DATA, 32'hABCD_0001);
        wr(`DBGST_IDX_DWA + 8'h01, 32'h0000_4000);
        wr(`DBGST_IDX_DWB + 8'h01, 32'h0000_5000);
        wr(`DBGST_IDX_DWC + 8'h01, 32'h0002_0005);
        leave();
        mem_valid <= 1'b1;
        mem_load <= 1'b1;
        mem_thread <= 3'h1;
        mem_addr <= 32'h0000_4000;
        @(posedge hclk);
        mem_valid <= 1'b0;
        quiet();
        host();
        wr(`DBGST_IDX_DWB + 8'h01, 32'h0000_4000);
        leave();
        mem_valid <= 1'b1;
        @(posedge hclk);
        mem_valid <= 1'b0;
        enter(cw(2'd1, 8'h01, `DBGST_CAUSE_DWATCH));
        rdc(`DBGST_IDX_DATA, 32'h0000_4000);
    endtask : t_watch

    // ==================================================================
    // main sequence: reset held twelve cycles, then each scenario
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_entry();
        t_halt_mbox();
        t_ibreak();
        t_watch();
        wrap_up();
    end
endmodule : dbgst_top_tb
